// *** src/ssp_sram_pins.sv ***
// pipelined synchronous memory behind its pins, with flip-flop storage
// assumes the controller drives all synchronous pins from i_clock
//
// Function
// - the address on the address pins is captured at the rising edge and picks one location.
// - the four active-low lane selects each govern one data byte and its parity bit.
// - a lane is written only when its lane select and write enable are both active.
// - write enable is sampled only on qualified edges and must be low to start a write.
// - advance/load high on a qualified edge steps the burst counter.
// - advance/load low on a qualified edge loads a fresh address for a new access.
// - an edge counts, and inputs other than the burst order strap are captured, only while clock enable is low.
// - three chip enables, first and third low-active, second high-active, are sampled.
// - output enable acts without the clock and lets read data drive the pins when low.
// - with output enable high the data and parity pins are undriven inputs.
// - pins stay undriven in a write data phase, the first clock out of deselect and deselect.
// - clock enable high holds every state except the strap flops and settle count, stretching the previous cycle.
// - the burst order strap picks interleaved when high and linear when low.
module ssp_sram_pins
    import ssp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int MEM_AW = MEM_AW_DEF
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [LANES-1:0]  i_byte_lane_write_sel_n,
    input  wire logic              i_write_en_n,
    input  wire logic              i_advance_or_load,
    input  wire logic              i_clock_qualify_n,
    input  wire logic              i_select_low_first_n,
    input  wire logic              i_select_high_second,
    input  wire logic              i_select_low_third_n,
    input  wire logic              i_out_en_n,
    input  wire logic              i_burst_mode_strap,
    input  wire logic [DATA_W-1:0] i_dq,
    input  wire logic [LANES-1:0]  i_parity_pins,
    output logic      [DATA_W-1:0] o_dq,
    output logic      [LANES-1:0]  o_parity_pins,
    output logic                   o_dq_oe_n
);
    localparam int DEPTH = 1 << MEM_AW;

    // the burst step keeps address bits above the burst field, so at least one must exist
    if (MEM_AW <= BURST_W || MEM_AW > ADDR_W || MEM_AW > 12) begin : g_bad_mem_aw
        $error("ssp_sram_pins: MEM_AW out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]                          mode_sync;
        logic [1:0]                          mode_cnt;
        logic                                mode;
        logic                                desel;
        logic                                burst_v;
        logic                                burst_wr;
        logic [BURST_W-1:0]                  base_lsb;
        logic [BURST_W-1:0]                  cnt;
        logic                                st1_v;
        logic                                st1_wr;
        logic [MEM_AW-1:0]                   st1_a;
        logic [LANES-1:0]                    st1_bw;
        logic                                st2_v;
        logic                                st2_wr;
        logic [MEM_AW-1:0]                   st2_a;
        logic [LANES-1:0]                    st2_bw;
        logic                                drive;
        logic [LANES*LANE_W-1:0]             out_d;
        logic [DEPTH-1:0][LANES*LANE_W-1:0]  mem;
    } ssp_state_t;

    localparam ssp_state_t RESET_STATE = '{desel: 1'b1, default: '0};

    ssp_state_t         state_reg;
    ssp_state_t         state_next;
    logic               selected;
    logic [BURST_W-1:0] beat_next;
    logic [BURST_W-1:0] burst_lsb;

    // lane word: parity bit above its byte
    function automatic logic [LANE_W-1:0] lane_in(input logic [DATA_W-1:0] dq,
                                                   input logic [LANES-1:0]  par,
                                                   input int                l);
        lane_in = {par[l], dq[l*BYTE_W +: BYTE_W]};
    endfunction : lane_in

    assign selected  = !i_select_low_first_n && i_select_high_second
                       && !i_select_low_third_n;
    assign beat_next = BURST_W'(state_reg.cnt + BURST_STEP);

    ssp_burst_ctr u_burst (
        .i_base_lsb   (state_reg.base_lsb),
        .i_beat       (beat_next),
        .i_interleave (state_reg.mode),
        .o_lsb        (burst_lsb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        // strap: two flops, tracked until settled, then frozen
        state_next.mode_sync = {state_reg.mode_sync[0], i_burst_mode_strap};
        if (state_reg.mode_cnt != STRAP_SETTLE) begin
            state_next.mode_cnt = 2'(state_reg.mode_cnt + 2'h1);
            state_next.mode     = state_reg.mode_sync[1];
        end
        if (!i_clock_qualify_n) begin
            // data phase of a write: capture enabled lanes
            if (state_reg.st2_v && state_reg.st2_wr) begin
                for (int l = 0; l < LANES; l++) begin
                    if (state_reg.st2_bw[l]) begin
                        state_next.mem[state_reg.st2_a][l*LANE_W +: LANE_W] =
                            lane_in(i_dq, i_parity_pins, l);
                    end
                end
            end
            state_next.st2_v  = state_reg.st1_v;
            state_next.st2_wr = state_reg.st1_wr;
            state_next.st2_a  = state_reg.st1_a;
            state_next.st2_bw = state_reg.st1_bw;
            state_next.out_d  = state_reg.mem[state_reg.st1_a];
            state_next.st1_bw = ~i_byte_lane_write_sel_n & {LANES{~i_write_en_n}};
            if (!i_advance_or_load) begin
                if (selected) begin
                    state_next.st1_v    = 1'b1;
                    state_next.st1_wr   = !i_write_en_n;
                    state_next.st1_a    = i_addr[MEM_AW-1:0];
                    state_next.base_lsb = i_addr[BURST_W-1:0];
                    state_next.cnt      = BURST_START;
                    state_next.burst_v  = 1'b1;
                    state_next.burst_wr = !i_write_en_n;
                    state_next.desel    = 1'b0;
                end else begin
                    state_next.st1_v   = 1'b0;
                    state_next.burst_v = 1'b0;
                    state_next.desel   = 1'b1;
                end
            end else begin
                state_next.st1_v  = state_reg.burst_v;
                state_next.st1_wr = state_reg.burst_wr;
                state_next.cnt    = beat_next;
                state_next.st1_a  = {state_reg.st1_a[MEM_AW-1:BURST_W], burst_lsb};
            end
            // no drive while deselected, on emerging, or for a write beat
            state_next.drive = state_reg.st1_v && !state_reg.st1_wr
                               && !state_next.desel && !state_reg.desel;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            o_dq[l*BYTE_W +: BYTE_W] = state_reg.out_d[l*LANE_W +: BYTE_W];
            o_parity_pins[l]         = state_reg.out_d[l*LANE_W + BYTE_W];
        end
    end

    // output enable pin acts without the clock
    assign o_dq_oe_n = !state_reg.drive || i_out_en_n;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence s_load_read;
        !i_clock_qualify_n && !i_advance_or_load && selected && i_write_en_n;
    endsequence

    sequence s_load_write;
        !i_clock_qualify_n && !i_advance_or_load && selected && !i_write_en_n;
    endsequence

    sequence s_keep_going;
        !i_clock_qualify_n && (i_advance_or_load || selected);
    endsequence

    property p_read_drive;
        s_load_read ##1 s_keep_going |=> state_reg.drive;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read did not drive after two edges");

    property p_write_quiet;
        s_load_write ##1 !i_clock_qualify_n |=> !state_reg.drive;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("pins driven in write data phase");

    property p_desel_quiet;
        !i_clock_qualify_n && !i_advance_or_load && !selected |=> o_dq_oe_n;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("pins driven while deselected");

    property p_oe_high;
        i_out_en_n |-> o_dq_oe_n;
    endproperty
    a_oe_high: assert property (p_oe_high)
        else $error("pins driven with output enable high");

    property p_oe_low;
        !i_out_en_n && state_reg.drive |-> !o_dq_oe_n;
    endproperty
    a_oe_low: assert property (p_oe_low)
        else $error("read data blocked with output enable low");

    property p_hold;
        i_clock_qualify_n |=> $stable(state_reg.st1_a) && $stable(state_reg.st2_v)
                              && $stable(state_reg.drive) && $stable(state_reg.cnt);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved on a masked edge");

    property p_advance;
        !i_clock_qualify_n && i_advance_or_load |=>
            state_reg.cnt == 2'($past(state_reg.cnt) + 2'h1);
    endproperty
    a_advance: assert property (p_advance)
        else $error("burst counter did not step");

    property p_order;
        !i_clock_qualify_n && i_advance_or_load |=>
            state_reg.st1_a[BURST_W-1:0] == ((state_reg.mode == MODE_INTERLEAVE)
                ? (state_reg.base_lsb ^ state_reg.cnt)
                : 2'(state_reg.base_lsb + state_reg.cnt));
    endproperty
    a_order: assert property (p_order)
        else $error("burst address off sequence");

    property p_lane_write;
        !i_clock_qualify_n && state_reg.st2_v && state_reg.st2_wr && state_reg.st2_bw[0]
        |=> state_reg.mem[$past(state_reg.st2_a)][LANE_W-1:0]
            == {$past(i_parity_pins[0]), $past(i_dq[BYTE_W-1:0])};
    endproperty
    a_lane_write: assert property (p_lane_write)
        else $error("lane a byte or parity not written");

    property p_lane_skip;
        !i_clock_qualify_n && state_reg.st2_v && !state_reg.st2_bw[1]
        |=> state_reg.mem[$past(state_reg.st2_a)][2*LANE_W-1:LANE_W]
            == $past(state_reg.mem[state_reg.st2_a][2*LANE_W-1:LANE_W]);
    endproperty
    a_lane_skip: assert property (p_lane_skip)
        else $error("unselected lane b written");

    sequence s_load_sel;
        !i_clock_qualify_n && !i_advance_or_load && selected;
    endsequence

    property p_load_addr;
        s_load_sel |=> state_reg.st1_a == $past(i_addr[MEM_AW-1:0])
                       && state_reg.cnt == BURST_START;
    endproperty
    a_load_addr: assert property (p_load_addr)
        else $error("fresh address not loaded");

    property p_load_kind;
        s_load_sel |=> state_reg.st1_v && (state_reg.st1_wr == !$past(i_write_en_n));
    endproperty
    a_load_kind: assert property (p_load_kind)
        else $error("access type not taken from write enable");

    property p_lane_sel;
        !i_clock_qualify_n |=>
            state_reg.st1_bw == ($past(i_write_en_n) ? '0 : ~$past(i_byte_lane_write_sel_n));
    endproperty
    a_lane_sel: assert property (p_lane_sel)
        else $error("lane enables not qualified by write enable");

    property p_read_data;
        !i_clock_qualify_n |=> state_reg.out_d == $past(state_reg.mem[state_reg.st1_a]);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("output word not taken from the addressed location");

    property p_desel_hold;
        !i_clock_qualify_n && !i_advance_or_load && !selected
        |=> state_reg.desel && !state_reg.st1_v;
    endproperty
    a_desel_hold: assert property (p_desel_hold)
        else $error("access started without a full select");

    property p_emerge_quiet;
        !i_clock_qualify_n && state_reg.desel |=> o_dq_oe_n;
    endproperty
    a_emerge_quiet: assert property (p_emerge_quiet)
        else $error("pins driven on first clock out of deselect");

    property p_burst_kind;
        !i_clock_qualify_n && i_advance_or_load
        |=> state_reg.st1_v == $past(state_reg.burst_v)
            && state_reg.st1_wr == $past(state_reg.burst_wr);
    endproperty
    a_burst_kind: assert property (p_burst_kind)
        else $error("burst beat lost the access type of its load");

    property p_mode_frozen;
        state_reg.mode_cnt == STRAP_SETTLE |=> $stable(state_reg.mode);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("burst order moved after settling");
endmodule : ssp_sram_pins

// *** src/ssp_pkg.sv ***
// constants shared by the synchronous memory pin interface
// assumes one clock; all control pins are launched on that clock by the controller
package ssp_pkg;
    localparam int             CLK_PERIOD_NS  = 20;
    localparam int             ADDR_W_DEF     = 20;
    localparam int             MEM_AW_DEF     = 6;
    localparam int             LANES          = 4;
    localparam int             BYTE_W         = 8;
    localparam int             LANE_W         = BYTE_W + 1;
    localparam int             DATA_W         = LANES * BYTE_W;
    localparam int             BURST_W        = 2;
    localparam logic           MODE_INTERLEAVE = 1'b1;
    localparam logic [1:0]     STRAP_SETTLE   = 2'h3;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
endpackage : ssp_pkg

// *** src/ssp_burst_ctr.sv ***
// burst sequence: low address bits for a given beat
// assumes base comes from a register of the caller and beat is the caller's counter register plus one
module ssp_burst_ctr
    import ssp_pkg::*;
(
    input  wire logic [BURST_W-1:0] i_base_lsb,
    input  wire logic [BURST_W-1:0] i_beat,
    input  wire logic               i_interleave,
    output logic      [BURST_W-1:0] o_lsb
);
    // interleaved xors the beat, linear adds it with wrap
    always_comb begin
        if (i_interleave == MODE_INTERLEAVE) begin
            o_lsb = i_base_lsb ^ i_beat;
        end else begin
            o_lsb = BURST_W'(i_base_lsb + i_beat);
        end
    end
endmodule : ssp_burst_ctr

// *** sim/ssp_host_model.sv ***
// controller model driving the memory's synchronous pins
// assumes the bench calls beat once per rising edge, nothing else drives these
module ssp_host_model
    import ssp_pkg::*;
(
    input  wire logic                  i_clock,
    output logic      [ADDR_W_DEF-1:0] o_addr,
    output logic      [LANES-1:0]      o_bw_n,
    output logic                       o_we_n,
    output logic                       o_adv,
    output logic                       o_qual_n,
    output logic      [2:0]            o_sel,
    output logic      [LANES*LANE_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_addr   = '0;
        o_bw_n   = 4'hf;
        o_we_n   = 1'b1;
        o_adv    = 1'b0;
        o_qual_n = 1'b0;
        o_sel    = 3'h4;
        o_data   = '0;
    end

    // one beat: launch after the falling edge, held through the rising edge
    task automatic beat(input logic q, input logic adv, input logic [2:0] sel,
                        input logic we_n, input logic [3:0] bw_n,
                        input int a, input logic [35:0] d);
        @(negedge i_clock);
        o_qual_n = q;
        o_adv    = adv;
        o_sel    = sel;
        o_we_n   = we_n;
        o_bw_n   = bw_n;
        o_addr   = ADDR_W_DEF'(a);
        o_data   = d;
        @(posedge i_clock);
    endtask : beat
endmodule : ssp_host_model

// *** sim/tb_top.sv ***
// self-checking bench for the memory pin interface
// assumes the host model owns all synchronous pins
module tb_top
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0]  SEL  = 3'h2;
    localparam logic [35:0] JUNK = 36'h5_5aa5_a55a;
    logic                  clk, rst, strap, oe_in_n, we_n, adv, qual_n, oe_n;
    logic [ADDR_W_DEF-1:0] addr;
    logic [3:0]            bw_n, par_o;
    logic [2:0]            sel;
    logic [35:0]           data;
    logic [31:0]           dq_o;
    int                    n_errors = 0;
    int                    checked  = 0;

    ssp_host_model host (.i_clock(clk), .o_addr(addr), .o_bw_n(bw_n), .o_we_n(we_n),
        .o_adv(adv), .o_qual_n(qual_n), .o_sel(sel), .o_data(data));
    ssp_sram_pins dut (.i_clock(clk), .i_rst(rst), .i_addr(addr),
        .i_byte_lane_write_sel_n(bw_n), .i_write_en_n(we_n), .i_advance_or_load(adv),
        .i_clock_qualify_n(qual_n), .i_select_low_first_n(sel[2]),
        .i_select_high_second(sel[1]), .i_select_low_third_n(sel[0]),
        .i_out_en_n(oe_in_n), .i_burst_mode_strap(strap), .i_dq(data[31:0]),
        .i_parity_pins(data[35:32]), .o_dq(dq_o), .o_parity_pins(par_o), .o_dq_oe_n(oe_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk_word(input string nm, input logic [35:0] e, input logic [35:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk_word
    task automatic chk_flag(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %b seen %b", nm, e, g);
            n_errors++;
        end
    endtask : chk_flag
    function automatic logic [35:0] wd(input int n);
        return 36'(n) * 36'h1_1111_1111;
    endfunction : wd
    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic s);
        @(negedge clk);
        rst = 1'b1;
        strap = s;
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk_word("data in reset", 36'h0, {par_o, dq_o});
        chk_flag("oe in reset", 1'b1, oe_n);
        repeat (3) host.beat(0, 0, 3'h4, 1, 4'hf, 0, JUNK);
    endtask : do_reset
    // command, then data two qualified edges later
    task automatic wr(input logic [2:0] s, input int a, input logic [3:0] b, input logic [35:0] d);
        host.beat(0, 0, s, 0, b, a, JUNK);
        host.beat(0, 0, SEL, 1, 4'h0, 0, JUNK);
        host.beat(0, 0, SEL, 1, 4'h0, 0, d);
    endtask : wr
    task automatic rd(input int a, input logic [35:0] e);
        host.beat(0, 0, SEL, 1, 4'h0, a, JUNK);
        host.beat(0, 0, SEL, 1, 4'h0, 0, JUNK);
        #2;
        chk_word("read data", e, {par_o, dq_o});
        chk_flag("read drive", 1'b0, oe_n);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    task automatic s_lanes();
        logic [35:0] e;
        wr(SEL, 0, 4'h0, wd(7));
        wr(SEL, 5, 4'h0, wd(1));
        wr(SEL, 5, 4'ha, wd(2));
        // lanes a and c from the second word
        e = (wd(1) & ~36'h5_00ff_00ff) | (wd(2) & 36'h5_00ff_00ff);
        rd(5, e);
        rd(0, wd(7));
    endtask : s_lanes
    task automatic s_chipsel();
        wr(SEL, 9, 4'h0, wd(9));
        for (int c = 0; c < 8; c++) if (c != 2) wr(3'(c), 9, 4'h0, ~wd(9));
        rd(9, wd(9));
    endtask : s_chipsel
    task automatic s_mask();
        host.beat(0, 0, SEL, 0, 4'h0, 10, JUNK);
        host.beat(1, 0, SEL, 0, 4'h0, 10, ~wd(10));
        host.beat(0, 0, SEL, 1, 4'h0, 0, JUNK);
        host.beat(0, 0, SEL, 1, 4'h0, 0, wd(10));
        rd(10, wd(10));
    endtask : s_mask
    task automatic s_drive();
        host.beat(0, 0, 3'h4, 1, 4'hf, 0, JUNK);
        #2 chk_flag("deselected drive", 1'b1, oe_n);
        host.beat(0, 0, SEL, 1, 4'hf, 0, JUNK);
        #2 chk_flag("emerging drive", 1'b1, oe_n);
        host.beat(0, 0, SEL, 1, 4'hf, 0, JUNK);
        host.beat(0, 0, SEL, 1, 4'hf, 0, JUNK);
        #2 chk_flag("read drive", 1'b0, oe_n);
        @(negedge clk) oe_in_n = 1'b1;
        #1 chk_flag("oe high", 1'b1, oe_n);
        oe_in_n = 1'b0;
        #1 chk_flag("oe low", 1'b0, oe_n);
        host.beat(0, 0, SEL, 0, 4'hf, 0, JUNK);
        host.beat(0, 0, SEL, 1, 4'hf, 0, JUNK);
        #2 chk_flag("write phase drive", 1'b1, oe_n);
    endtask : s_drive
    task automatic s_burst(input logic m);
        do_reset(m);
        for (int i = 8; i < 12; i++) wr(SEL, i, 4'h0, wd(i));
        host.beat(0, 0, SEL, 1, 4'hf, 9, JUNK);
        for (int k = 0; k < 4; k++) begin
            host.beat(0, k < 3, SEL, 1, 4'hf, 0, JUNK);
            #2 chk_word("burst beat", wd(m ? (9 ^ k) : 8 + ((1 + k) & 3)), {par_o, dq_o});
        end
    endtask : s_burst
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        strap = 1'b1;
        oe_in_n = 1'b0;
        do_reset(1'b1);
        s_lanes();
        s_chipsel();
        s_mask();
        s_drive();
        s_burst(1'b1);
        s_burst(1'b0);
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top
